// ==== rtl/plc_cell.v ====
// Purpose: logic cell with two sum-of-products arrays and 8-bit datapath
// Assumes: single cell clock and reset, inputs synchronous to CLK_I
// Notes: chain outputs and array outputs in combinational mode are
//   combinational by nature; everything else leaves from a flop
// Overview of operation
// [RL1] each array: twelve inputs, eight product terms
// [RL2] terms AND chosen true or inverted inputs
// [RL3] outputs OR a chosen set of terms
// [RL4] OR width fixed at eight everywhere
// [RL5] two arrays, outputs registered or combinational
// [RL6] eight-bit datapath, one operation per cycle
// [RL7] six working registers reachable by the bus
// [RL8] accumulators feed alu, take results, compare
// [RL9] operand registers feed alu and compares
// [RL10] four-byte queues load and capture registers
// [RL11] eight sixteen-bit words select cycle function
// [RL12] outside logic drives word address each cycle
// [RL13] alu has eight listed functions
// [RL14] pass forwards operand unchanged
// [RL15] shift, swap, or-mask follow alu independently
// [RL16] two comparators with bit masks
// [RL17] compare operands chosen among four registers
// [RL18] zero, ones, overflow; chosen conditions routed out
// [RL19] chain signals extend compares to neighbours
// [RL20] programmable msb gives arbitrary width
// [RL21] each queue input or output buffer
// [RL22] state updates on clock, clears on reset; queue bytes and configuration words are not cleared
`timescale 1ns/1ps
`default_nettype none
`include "plc_defines.vh"

module plc_cell #(
  parameter QAW = `PLC_QUEUE_AW
) (
  input wire CLK_I, // cell clock, 40 MHz
  input wire RST_N_I, // asynchronous reset, active low
  input wire [23:0] PLD_IN_I, // twelve routed inputs per array
  input wire [191:0] PLD_T_CFG_I, // true-input use per term
  input wire [191:0] PLD_C_CFG_I, // inverted-input use per term
  input wire [63:0] PLD_OR_CFG_I, // term selection per output
  input wire [7:0] PLD_REG_CFG_I, // 1 selects registered output
  output wire [7:0] PLD_OUT_O, // array outputs
  input wire BUS_WR_I, // working register write strobe
  input wire BUS_RD_I, // working register read request
  input wire [2:0] BUS_SEL_I, // working register select
  input wire [7:0] BUS_WDATA_I, // write data
  output reg BUS_RD_READY_O, // read request may be taken
  output reg BUS_RVALID_O, // read data valid
  input wire BUS_RREADY_I, // reader takes the data
  output reg [7:0] BUS_RDATA_O, // read data
  input wire CFG_WE_I, // configuration word write
  input wire [2:0] CFG_WADDR_I, // configuration write address
  input wire [15:0] CFG_WDATA_I, // configuration write data
  input wire [2:0] CFG_ADDR_I, // configuration address from routing
  input wire [2:0] MSB_SEL_I, // most significant bit position
  input wire [7:0] OR_MASK_I, // output or-mask
  input wire [7:0] CMP0_MASK_I, // compare 0 bit mask
  input wire [7:0] CMP1_MASK_I, // compare 1 bit mask
  input wire [1:0] CMP_SEL_I, // compare operand selection
  input wire [1:0] Q_DIR_I, // per queue: 1 output buffer
  input wire [1:0] Q_CAP_SEL_I, // per queue: 1 captures accumulator
  input wire [23:0] OUT_SEL_I, // condition pick per output
  output reg [5:0] COND_O, // conditions to routing
  input wire SI_I, // shift data in
  output wire SO_O, // shift data out, chain
  input wire CHAIN_CI_I, // carry in from neighbour
  output wire CHAIN_CO_O, // carry out to neighbour
  input wire CHAIN_EQ_I, // compare 0 equal from neighbour
  output wire CHAIN_EQ_O, // compare 0 equal to neighbour
  input wire CHAIN_Z_I, // result zero from neighbour
  output wire CHAIN_Z_O // result zero to neighbour
);

  localparam [QAW:0] QDEPTH = {1'b1, {QAW{1'b0}}};
  localparam QN = 1 << QAW;

  // one product term: every used input form must be true
  function pt_eval;
    input [11:0] in_v, t_v, c_v; // inputs, true use, inverted use
    begin
      pt_eval = &((in_v | ~t_v) & (~in_v | ~c_v));
    end
  endfunction
  // width mask up to the programmed msb
  function [7:0] width_mask;
    input [2:0] msb;
    begin
      width_mask = 8'hFF >> (3'h7 - msb);
    end
  endfunction
  wire [15:0] pt_w; // product terms, eight per array
  wire [7:0] sop_w; // combinational sums
  reg [7:0] pld_ff; // registered sums
  genvar g, t, k;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_arr
      // [RL1] twelve inputs feed terms
      for (t = 0; t < 8; t = t + 1) begin : g_term
        // [RL2] true or inverted
        assign pt_w[g*8+t] = pt_eval(PLD_IN_I[g*12 +: 12],
          PLD_T_CFG_I[(g*8+t)*12 +: 12], PLD_C_CFG_I[(g*8+t)*12 +: 12]);
      end
      for (k = 0; k < 4; k = k + 1) begin : g_out
        // [RL3] [RL4] eight-wide sum
        assign sop_w[g*4+k] = |(pt_w[g*8 +: 8] & PLD_OR_CFG_I[(g*4+k)*8 +: 8]);
        // [RL5] registered or combinational
        assign PLD_OUT_O[g*4+k] = PLD_REG_CFG_I[g*4+k] ? pld_ff[g*4+k]
                                                       : sop_w[g*4+k];
      end
    end
  endgenerate

  // [RL22] registered array state
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pld_ff <= 8'h00;
    end else begin
      pld_ff <= sop_w;
    end
  end
  wire [15:0] cfg_w; // word steering this cycle
  // [RL11] [RL12] word picked by routed address
  plc_cfg_ram u_cfg (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .we_i(CFG_WE_I),
    .waddr_i(CFG_WADDR_I),
    .wdata_i(CFG_WDATA_I),
    .raddr_i(CFG_ADDR_I),
    .rdata_o(cfg_w)
  );

  wire [2:0] func_w = cfg_w[`PLC_CF_FUNC +: 3]; // alu function
  wire [1:0] bsel_w = cfg_w[`PLC_CF_BSEL +: 2]; // second operand
  wire [1:0] shop_w = cfg_w[`PLC_CF_SHIFT +: 2]; // post alu stage
  wire [1:0] a0wr_w = cfg_w[`PLC_CF_A0WR +: 2]; // accumulator 0 source
  wire [1:0] a1wr_w = cfg_w[`PLC_CF_A1WR +: 2]; // accumulator 1 source
  reg [7:0] accumulator_zero_ff; // accumulator 0
  reg [7:0] accumulator_one_ff; // accumulator 1
  reg [7:0] operand_register_zero_ff; // operand register 0
  reg [7:0] operand_register_one_ff; // operand register 1
  wire [15:0] q_head_w; // queue head bytes
  wire [1:0] q_empty_w; // queue empty flags
  wire [1:0] q_full_w; // queue full flags
  // alu, shifter and mask
  reg [7:0] wm, a_src, b_src, b_eff; // width mask, operands, addend
  reg [8:0] sum; // arithmetic sum with carry
  reg [7:0] alu_r, sh_r, dp_res; // alu, shifter and final results
  reg cin, arith; // carry into bit 0, arithmetic function active
  reg co, ov, so; // carry and overflow at msb, shift out bit

  // [RL6] single cycle alu path
  always @* begin
    wm = width_mask(MSB_SEL_I);
    // [RL8] accumulator operand
    a_src = cfg_w[`PLC_CF_ASEL] ? accumulator_one_ff : accumulator_zero_ff;
    // [RL9] operand register sources
    b_src = bsel_w[1] ? (bsel_w[0] ? accumulator_one_ff : accumulator_zero_ff)
      : (bsel_w[0] ? operand_register_one_ff : operand_register_zero_ff);
    b_eff = 8'h00;
    cin = 1'b0;
    arith = 1'b1;
    // [RL13] eight functions
    case (func_w)
      `PLC_ALU_INC: cin = 1'b1;
      `PLC_ALU_DEC: b_eff = wm;
      `PLC_ALU_ADD: begin
        b_eff = b_src & wm;
        cin = CHAIN_CI_I;
      end
      `PLC_ALU_SUB: begin
        b_eff = ~b_src & wm;
        cin = CHAIN_CI_I;
      end
      default: arith = 1'b0;
    endcase
    sum = {1'b0, a_src & wm} + {1'b0, b_eff} + {8'h00, cin};
    case (func_w)
      `PLC_ALU_AND: alu_r = a_src & b_src;
      `PLC_ALU_OR: alu_r = a_src | b_src;
      `PLC_ALU_XOR: alu_r = a_src ^ b_src;
      // [RL14] pass unchanged
      `PLC_ALU_PASS: alu_r = a_src;
      default: alu_r = sum[7:0];
    endcase
    // [RL20] carry and overflow at msb
    co = arith & sum[{1'b0, MSB_SEL_I} + 4'h1];
    ov = arith & (a_src[MSB_SEL_I] == b_eff[MSB_SEL_I])
                & (sum[MSB_SEL_I] != a_src[MSB_SEL_I]);
    // [RL15] post alu stage
    so = 1'b0;
    case (shop_w)
      `PLC_SH_LEFT: begin
        sh_r = {alu_r[6:0], SI_I} & wm;
        so = alu_r[MSB_SEL_I];
      end
      `PLC_SH_RIGHT: begin
        sh_r = ((alu_r & wm) >> 1) | ({7'h00, SI_I} << MSB_SEL_I);
        so = alu_r[0];
      end
      `PLC_SH_SWAP: sh_r = {alu_r[3:0], alu_r[7:4]} & wm;
      default: sh_r = alu_r & wm;
    endcase
    // [RL15] or-mask
    dp_res = sh_r | OR_MASK_I;
  end
  assign SO_O = so;
  assign CHAIN_CO_O = co;
  // [RL17] compare operand choice
  wire [7:0] c0_l = (CMP_SEL_I[0] ? accumulator_one_ff
                                  : accumulator_zero_ff) & CMP0_MASK_I;
  wire [7:0] c0_r = operand_register_zero_ff & CMP0_MASK_I;
  wire [7:0] c1_l = (CMP_SEL_I[1] ? accumulator_zero_ff
                                  : accumulator_one_ff) & CMP1_MASK_I;
  wire [7:0] c1_r = operand_register_one_ff & CMP1_MASK_I;
  wire [15:0] cond_w; // all generated conditions

  // [RL16] [RL19] masked compares, compare 0 equal chained
  assign cond_w[`PLC_CN_EQ0] = (c0_l == c0_r) & CHAIN_EQ_I;
  assign cond_w[`PLC_CN_LT0] = c0_l < c0_r;
  assign cond_w[`PLC_CN_EQ1] = c1_l == c1_r;
  assign cond_w[`PLC_CN_LT1] = c1_l < c1_r;
  // [RL18] zero, all ones, overflow
  assign cond_w[`PLC_CN_Z0] = (accumulator_zero_ff & wm) == 8'h00;
  assign cond_w[`PLC_CN_Z1] = (accumulator_one_ff & wm) == 8'h00;
  assign cond_w[`PLC_CN_FF0] = (accumulator_zero_ff & wm) == wm;
  assign cond_w[`PLC_CN_FF1] = (accumulator_one_ff & wm) == wm;
  assign cond_w[`PLC_CN_OV] = ov;
  assign cond_w[`PLC_CN_CO] = co;
  assign cond_w[`PLC_CN_SO] = so;
  assign cond_w[`PLC_CN_Q0E] = q_empty_w[0];
  assign cond_w[`PLC_CN_Q0F] = q_full_w[0];
  assign cond_w[`PLC_CN_Q1E] = q_empty_w[1];
  assign cond_w[`PLC_CN_Q1F] = q_full_w[1];
  // [RL19] chained result zero
  assign cond_w[`PLC_CN_RZ] = (dp_res == 8'h00) & CHAIN_Z_I;
  assign CHAIN_EQ_O = cond_w[`PLC_CN_EQ0];
  assign CHAIN_Z_O = cond_w[`PLC_CN_RZ];

  // [RL18] selected conditions to routing
  integer j;
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      COND_O <= 6'h00;
    end else begin
      for (j = 0; j < 6; j = j + 1) begin
        COND_O[j] <= cond_w[OUT_SEL_I[j*4 +: 4]];
      end
    end
  end

  // byte queues
  wire rd_take = BUS_RD_I & BUS_RD_READY_O; // read request taken
  wire [1:0] q_ld_w; // internal pop for a register load
  genvar q;
  generate
    for (q = 0; q < 2; q = q + 1) begin : g_queue
      reg [7:0] mem_ff [0:QN-1]; // queue bytes
      reg [QAW-1:0] wp_ff; // write pointer
      reg [QAW-1:0] rp_ff; // read pointer
      reg [QAW:0] cnt_ff; // bytes held
      wire is_out = Q_DIR_I[q]; // 1 output buffer
      // bus select names this queue
      wire bus_hit = BUS_SEL_I == (q ? `PLC_SEL_QUE1 : `PLC_SEL_QUE0);
      wire [7:0] acc = q ? accumulator_one_ff : accumulator_zero_ff;
      // [RL21] direction picks writer and reader
      wire [7:0] wdata = ~is_out ? BUS_WDATA_I
                       : Q_CAP_SEL_I[q] ? acc : dp_res; // byte pushed
      wire push = ~q_full_w[q] & (is_out ? cfg_w[`PLC_CF_Q0PUSH + q]
                                         : BUS_WR_I & bus_hit); // write taken
      // [RL10] internal pop on a register load
      assign q_ld_w[q] = ~is_out & ~q_empty_w[q]
                       & ((cfg_w[`PLC_CF_A0WR + 2*q +: 2] == `PLC_AW_QUEUE)
                          | cfg_w[`PLC_CF_D0LD + q]);
      wire pop = q_ld_w[q] | (is_out & ~q_empty_w[q] & rd_take & bus_hit);
      // byte storage, contents need no reset
      always @(posedge CLK_I) begin
        if (push) begin
          mem_ff[wp_ff] <= wdata;
        end
      end
      // [RL10] [RL22] pointers and count
      always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          wp_ff <= {QAW{1'b0}};
          rp_ff <= {QAW{1'b0}};
          cnt_ff <= {(QAW+1){1'b0}};
        end else begin
          if (push) begin
            wp_ff <= wp_ff + 1'b1;
          end
          if (pop) begin
            rp_ff <= rp_ff + 1'b1;
          end
          cnt_ff <= cnt_ff + {{QAW{1'b0}}, push} - {{QAW{1'b0}}, pop};
        end
      end
      assign q_head_w[q*8 +: 8] = mem_ff[rp_ff];
      assign q_empty_w[q] = cnt_ff == {(QAW+1){1'b0}};
      assign q_full_w[q] = cnt_ff == QDEPTH;
    end
  endgenerate

  // bus write strobes of the four plain registers
  wire wr_a0 = BUS_WR_I & (BUS_SEL_I == `PLC_SEL_ACC0);
  wire wr_a1 = BUS_WR_I & (BUS_SEL_I == `PLC_SEL_ACC1);
  wire wr_d0 = BUS_WR_I & (BUS_SEL_I == `PLC_SEL_OPR0);
  wire wr_d1 = BUS_WR_I & (BUS_SEL_I == `PLC_SEL_OPR1);
  // [RL7] [RL8] bus write wins over datapath
  wire [7:0] nxt_acc0 = wr_a0 ? BUS_WDATA_I
    : (a0wr_w == `PLC_AW_ALU) ? dp_res
    : ((a0wr_w == `PLC_AW_QUEUE) & q_ld_w[0]) ? q_head_w[7:0]
    : accumulator_zero_ff; // next accumulator 0
  wire [7:0] nxt_acc1 = wr_a1 ? BUS_WDATA_I
    : (a1wr_w == `PLC_AW_ALU) ? dp_res
    : ((a1wr_w == `PLC_AW_QUEUE) & q_ld_w[1]) ? q_head_w[15:8]
    : accumulator_one_ff; // next accumulator 1
  // [RL10] operand registers load from queues
  wire [7:0] nxt_opr0 = wr_d0 ? BUS_WDATA_I
    : (cfg_w[`PLC_CF_D0LD] & q_ld_w[0]) ? q_head_w[7:0]
    : operand_register_zero_ff; // next operand register 0
  wire [7:0] nxt_opr1 = wr_d1 ? BUS_WDATA_I
    : (cfg_w[`PLC_CF_D1LD] & q_ld_w[1]) ? q_head_w[15:8]
    : operand_register_one_ff; // next operand register 1
  // [RL22] working registers
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      accumulator_zero_ff <= `PLC_RST_BYTE;
      accumulator_one_ff <= `PLC_RST_BYTE;
      operand_register_zero_ff <= `PLC_RST_BYTE;
      operand_register_one_ff <= `PLC_RST_BYTE;
    end else begin
      accumulator_zero_ff <= nxt_acc0;
      accumulator_one_ff <= nxt_acc1;
      operand_register_zero_ff <= nxt_opr0;
      operand_register_one_ff <= nxt_opr1;
    end
  end
  // read path with two-entry buffer
  reg [7:0] rd_data; // selected read byte
  // [RL7] read select
  always @* begin
    case (BUS_SEL_I)
      `PLC_SEL_ACC0: rd_data = accumulator_zero_ff;
      `PLC_SEL_ACC1: rd_data = accumulator_one_ff;
      `PLC_SEL_OPR0: rd_data = operand_register_zero_ff;
      `PLC_SEL_OPR1: rd_data = operand_register_one_ff;
      // [RL21] only output queues give data
      `PLC_SEL_QUE0: rd_data = (Q_DIR_I[0] & ~q_empty_w[0]) ? q_head_w[7:0]
                                                           : 8'h00;
      `PLC_SEL_QUE1: rd_data = (Q_DIR_I[1] & ~q_empty_w[1]) ? q_head_w[15:8]
                                                           : 8'h00;
      default: rd_data = 8'h00;
    endcase
  end

  reg [7:0] rb1_ff; // second buffer entry
  reg [1:0] rcnt_ff; // entries held
  wire rd_pop = BUS_RVALID_O & BUS_RREADY_I; // reader takes head
  // next entry count; a take never meets a full buffer
  wire [1:0] nxt_rcnt = rcnt_ff + {1'b0, rd_take} - {1'b0, rd_pop};
  // buffer registers and registered handshakes
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUS_RDATA_O <= `PLC_RST_BYTE;
      rb1_ff <= `PLC_RST_BYTE;
      rcnt_ff <= 2'h0;
      BUS_RVALID_O <= 1'b0;
      BUS_RD_READY_O <= 1'b1;
    end else begin
      // free or popped head refills from second entry or fresh byte
      if (rd_pop | ~BUS_RVALID_O) begin
        BUS_RDATA_O <= rcnt_ff[1] ? rb1_ff : rd_data;
      end
      // fresh byte parks behind a head that stays
      if (rd_take & BUS_RVALID_O & ~rd_pop) begin
        rb1_ff <= rd_data;
      end
      rcnt_ff <= nxt_rcnt;
      BUS_RVALID_O <= nxt_rcnt != 2'h0;
      BUS_RD_READY_O <= nxt_rcnt != 2'h2;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/plc_defines.vh ====
// Purpose: shared constants of the programmable logic cell
// Assumes: included by every design file of the cell
// Notes: definitions only, no logic
`ifndef PLC_DEFINES_VH
`define PLC_DEFINES_VH

// register select codes of the working register port
`define PLC_SEL_ACC0 3'h0
`define PLC_SEL_ACC1 3'h1
`define PLC_SEL_OPR0 3'h2
`define PLC_SEL_OPR1 3'h3
`define PLC_SEL_QUE0 3'h4
`define PLC_SEL_QUE1 3'h5

// reset values
`define PLC_RST_BYTE 8'h00
`define PLC_RST_CFG 16'h0000

// alu function codes
`define PLC_ALU_PASS 3'h0
`define PLC_ALU_INC 3'h1
`define PLC_ALU_DEC 3'h2
`define PLC_ALU_ADD 3'h3
`define PLC_ALU_SUB 3'h4
`define PLC_ALU_AND 3'h5
`define PLC_ALU_OR 3'h6
`define PLC_ALU_XOR 3'h7

// post alu stage codes
`define PLC_SH_NONE 2'h0
`define PLC_SH_LEFT 2'h1
`define PLC_SH_RIGHT 2'h2
`define PLC_SH_SWAP 2'h3

// accumulator write source codes
`define PLC_AW_HOLD 2'h0
`define PLC_AW_ALU 2'h1
`define PLC_AW_QUEUE 2'h2

// configuration word field positions
`define PLC_CF_FUNC 0
`define PLC_CF_ASEL 3
`define PLC_CF_BSEL 4
`define PLC_CF_SHIFT 6
`define PLC_CF_A0WR 8
`define PLC_CF_A1WR 10
`define PLC_CF_D0LD 12
`define PLC_CF_D1LD 13
`define PLC_CF_Q0PUSH 14
`define PLC_CF_Q1PUSH 15

// configuration store geometry
`define PLC_CFG_WORDS 8
`define PLC_CFG_AW 3
`define PLC_CFG_DW 16

// byte queue depth as address bits (four bytes)
`define PLC_QUEUE_AW 2

// condition vector bit positions
`define PLC_CN_EQ0 0
`define PLC_CN_LT0 1
`define PLC_CN_EQ1 2
`define PLC_CN_LT1 3
`define PLC_CN_Z0 4
`define PLC_CN_Z1 5
`define PLC_CN_FF0 6
`define PLC_CN_FF1 7
`define PLC_CN_OV 8
`define PLC_CN_CO 9
`define PLC_CN_SO 10
`define PLC_CN_Q0E 11
`define PLC_CN_Q0F 12
`define PLC_CN_Q1E 13
`define PLC_CN_Q1F 14
`define PLC_CN_RZ 15

`endif

// ==== rtl/plc_cfg_ram.v ====
// Purpose: per-cycle configuration store of the cell datapath
// Assumes: one write port and one read port on the same clock
// Notes: read data come out of a register, so a word read
//   at one edge steers the datapath until the next edge
`timescale 1ns/1ps
`default_nettype none
`include "plc_defines.vh"

module plc_cfg_ram #(
  parameter AW = `PLC_CFG_AW,
  parameter DW = `PLC_CFG_DW
) (
  input wire clk_i, // cell clock
  input wire rst_n_i, // asynchronous reset, active low
  input wire we_i, // write strobe
  input wire [AW-1:0] waddr_i, // write address
  input wire [DW-1:0] wdata_i, // write data
  input wire [AW-1:0] raddr_i, // read address, may change each cycle
  output reg [DW-1:0] rdata_o // registered read data
);

  localparam NWORDS = 1 << AW;

  // storage words, no reset on the array itself
  reg [DW-1:0] mem_ff [0:NWORDS-1];

  // write port
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // registered read port, clears to a no-operation word
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `PLC_RST_CFG;
    end else begin
      rdata_o <= mem_ff[raddr_i];
    end
  end

endmodule
`default_nettype wire

// ==== bench/plc_reader.sv ====
// Purpose: bus reader model draining the cell read buffer
// Assumes: stall_i chooses slow acceptance
// Notes: ready moves only just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module plc_reader (
  input wire logic clk_i, // cell clock
  input wire logic rst_n_i, // reset, active low
  input wire logic stall_i, // 1 accepts one edge in four
  output logic rready_o // takes read data
);
  logic [1:0] cnt_ff; // stall pacing
  // pace acceptance, prompt or slow
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 2'h0;
      rready_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      rready_o <= !stall_i || (cnt_ff == 2'h3);
    end
  end
endmodule
`default_nettype wire

// ==== bench/plc_cell_props.sv ====
// Purpose: port checks of the logic cell
// Assumes: single clock, reset active low
// Notes: bound to plc_cell from the bench
`timescale 1ns/1ps
`default_nettype none
module plc_cell_props (
  input wire CLK_I, // cell clock
  input wire RST_N_I, // reset, active low
  input wire BUS_RD_I, // read request
  input wire BUS_RD_READY_O, // read may be taken
  input wire BUS_RVALID_O, // read data valid
  input wire BUS_RREADY_I, // reader takes data
  input wire [7:0] BUS_RDATA_O, // read data
  input wire [63:0] PLD_OR_CFG_I, // term selection
  input wire [7:0] PLD_REG_CFG_I, // registered select
  input wire [7:0] PLD_OUT_O, // array outputs
  input wire CHAIN_EQ_I, // equal chain in
  input wire CHAIN_EQ_O, // equal chain out
  input wire CHAIN_Z_I, // zero chain in
  input wire CHAIN_Z_O // zero chain out
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_rd_answer;
    BUS_RD_I && BUS_RD_READY_O && !BUS_RVALID_O |=> BUS_RVALID_O;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_rd_hold;
    BUS_RVALID_O && !BUS_RREADY_I |=> BUS_RVALID_O && $stable(BUS_RDATA_O);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped");
  property p_full_valid;
    !BUS_RD_READY_O |-> BUS_RVALID_O;
  endproperty
  a_full_valid: assert property (p_full_valid)
    else $error("refusing while empty");
  property p_keep_second;
    BUS_RVALID_O && BUS_RREADY_I && !BUS_RD_READY_O |=> BUS_RVALID_O;
  endproperty
  a_keep_second: assert property (p_keep_second)
    else $error("second entry lost");
  property p_or_none;
    PLD_OR_CFG_I == 64'h0 && PLD_REG_CFG_I == 8'h00 |-> PLD_OUT_O == 8'h00;
  endproperty
  a_or_none: assert property (p_or_none)
    else $error("output without terms");
  property p_eq_chain;
    !CHAIN_EQ_I |-> !CHAIN_EQ_O;
  endproperty
  a_eq_chain: assert property (p_eq_chain)
    else $error("equal chain ignored");
  property p_z_chain;
    !CHAIN_Z_I |-> !CHAIN_Z_O;
  endproperty
  a_z_chain: assert property (p_z_chain)
    else $error("zero chain ignored");
  property p_reset_idle;
    $rose(RST_N_I) |-> !BUS_RVALID_O && BUS_RD_READY_O[*2];
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle after reset");
  c_full: cover property (!BUS_RD_READY_O);
  c_take: cover property (BUS_RVALID_O && BUS_RREADY_I);
  c_chain: cover property (!CHAIN_Z_I);
endmodule
`default_nettype wire

// ==== bench/tb_programmable_logic_datapath_cell.sv ====
// Purpose: self-checking bench of the logic cell
// Assumes: plc_reader drains reads
// Notes: second reset clears state after config word 0
`timescale 1ns/1ps
`default_nettype none
module tb_programmable_logic_datapath_cell;
  logic CLK_I, RST_N_I, BUS_WR_I, BUS_RD_I, BUS_RREADY_I, CFG_WE_I, SI_I;
  logic CHAIN_CI_I, CHAIN_EQ_I, CHAIN_Z_I, BUS_RD_READY_O, BUS_RVALID_O;
  logic CHAIN_EQ_O, CHAIN_Z_O, stall, ci, p12;
  logic [1:0] CMP_SEL_I, Q_DIR_I, Q_CAP_SEL_I;
  logic [2:0] BUS_SEL_I, CFG_WADDR_I, CFG_ADDR_I, MSB_SEL_I, f;
  logic [7:0] BUS_WDATA_I, BUS_RDATA_O, OR_MASK_I, CMP0_MASK_I, CMP1_MASK_I;
  logic [7:0] PLD_REG_CFG_I, PLD_OUT_O, a, b, m, r;
  logic [7:0] v[4];
  logic [5:0] COND_O;
  logic [15:0] CFG_WDATA_I;
  logic [23:0] PLD_IN_I, OUT_SEL_I;
  logic [63:0] PLD_OR_CFG_I;
  logic [191:0] PLD_T_CFG_I, PLD_C_CFG_I;
  logic [7:0] exp_q[$], got_q[$];
  int mismatches, comparisons, cycles;
  plc_cell dut_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PLD_IN_I(PLD_IN_I),
    .PLD_T_CFG_I(PLD_T_CFG_I), .PLD_C_CFG_I(PLD_C_CFG_I),
    .PLD_OR_CFG_I(PLD_OR_CFG_I), .PLD_REG_CFG_I(PLD_REG_CFG_I),
    .PLD_OUT_O(PLD_OUT_O), .BUS_WR_I(BUS_WR_I), .BUS_RD_I(BUS_RD_I),
    .BUS_SEL_I(BUS_SEL_I), .BUS_WDATA_I(BUS_WDATA_I),
    .BUS_RD_READY_O(BUS_RD_READY_O), .BUS_RVALID_O(BUS_RVALID_O),
    .BUS_RREADY_I(BUS_RREADY_I), .BUS_RDATA_O(BUS_RDATA_O),
    .CFG_WE_I(CFG_WE_I), .CFG_WADDR_I(CFG_WADDR_I),
    .CFG_WDATA_I(CFG_WDATA_I), .CFG_ADDR_I(CFG_ADDR_I),
    .MSB_SEL_I(MSB_SEL_I), .OR_MASK_I(OR_MASK_I), .CMP0_MASK_I(CMP0_MASK_I),
    .CMP1_MASK_I(CMP1_MASK_I), .CMP_SEL_I(CMP_SEL_I), .Q_DIR_I(Q_DIR_I),
    .Q_CAP_SEL_I(Q_CAP_SEL_I), .OUT_SEL_I(OUT_SEL_I), .COND_O(COND_O),
    .SI_I(SI_I), .SO_O(), .CHAIN_CI_I(CHAIN_CI_I), .CHAIN_CO_O(),
    .CHAIN_EQ_I(CHAIN_EQ_I), .CHAIN_EQ_O(CHAIN_EQ_O),
    .CHAIN_Z_I(CHAIN_Z_I), .CHAIN_Z_O(CHAIN_Z_O));
  plc_reader rd_u (.clk_i(CLK_I), .rst_n_i(RST_N_I), .stall_i(stall),
    .rready_o(BUS_RREADY_I));
  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end
  // collect read data as the reader takes it
  always @(posedge CLK_I) begin
    cycles++;
    if (RST_N_I && BUS_RVALID_O === 1'b1 && BUS_RREADY_I === 1'b1)
      got_q.push_back(BUS_RDATA_O);
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    BUS_RD_I <= 1'b0;
    BUS_WR_I <= 1'b1;
    BUS_SEL_I <= s;
    BUS_WDATA_I <= d;
    tick(1);
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e);
    exp_q.push_back(e);
    BUS_WR_I <= 1'b0;
    BUS_RD_I <= 1'b1;
    BUS_SEL_I <= s;
    do tick(1); while (BUS_RD_READY_O !== 1'b1);
  endtask
  task automatic drain(input string nm);
    BUS_RD_I <= 1'b0;
    do tick(1); while (got_q.size() < exp_q.size());
    while (exp_q.size() > 0) chk(nm, got_q.pop_front(), exp_q.pop_front());
  endtask
  // one datapath operation from word 1, then back to hold word 0
  task automatic op(input logic [15:0] w);
    BUS_WR_I <= 1'b0;
    {CFG_WE_I, CFG_WADDR_I, CFG_WDATA_I} <= {4'h9, w};
    tick(1);
    CFG_WE_I <= 1'b0;
    CFG_ADDR_I <= 3'h1;
    tick(1);
    CFG_ADDR_I <= 3'h0;
    tick(3);
  endtask
  function automatic logic [7:0] alu(input logic [2:0] f, input logic [7:0] a,
      b, m, input logic ci);
    logic [7:0] r;
    case (f)
      3'h0: r = a;
      3'h1: r = a + 8'h01;
      3'h2: r = a - 8'h01;
      3'h3: r = a + b + {7'h00, ci};
      3'h4: r = a + ~b + {7'h00, ci};
      3'h5: r = a & b;
      3'h6: r = a | b;
      default: r = a ^ b;
    endcase
    case (f[1:0])
      2'h1: r = {r[6:0], 1'b0};
      2'h2: r = {1'b0, r[7:1]};
      2'h3: r = {r[3:0], r[7:4]};
      default: r = r;
    endcase
    return r | m;
  endfunction
  initial begin
    void'($urandom(14));
    {RST_N_I, BUS_WR_I, BUS_RD_I, SI_I, CHAIN_CI_I, stall} = 6'h00;
    {CHAIN_EQ_I, CHAIN_Z_I, MSB_SEL_I, CFG_WE_I} = 6'h3F;
    {BUS_SEL_I, CFG_WADDR_I, CFG_ADDR_I, CMP_SEL_I} = 11'h000;
    {BUS_WDATA_I, OR_MASK_I, CMP0_MASK_I, CMP1_MASK_I} = 32'h0;
    {PLD_REG_CFG_I, CFG_WDATA_I, PLD_IN_I, PLD_OR_CFG_I} = 112'h0;
    {PLD_T_CFG_I, PLD_C_CFG_I} = 384'h0;
    {OUT_SEL_I, Q_DIR_I, Q_CAP_SEL_I} = 28'hFEDCB4A;
    tick(6);
    RST_N_I <= 1'b1;
    tick(2);
    {RST_N_I, CFG_WE_I} <= 2'h0;
    tick(2);
    RST_N_I <= 1'b1;
    tick(1);
    for (int i = 0; i < 4; i++) wr(i[2:0], (v[i] = 8'($urandom)));
    for (int i = 0; i < 4; i++) rd(i[2:0], v[i]);
    rd(3'h6, 8'h00);
    drain("register");
    for (int i = 0; i < 8; i++) begin
      {f, a, b, m, ci} = {i[2:0], 25'($urandom)};
      m = m & 8'h11;
      wr(3'h0, a);
      wr(3'h2, b);
      {OR_MASK_I, CHAIN_CI_I} <= {m, ci};
      op({6'h00, 2'h1, f[1:0], 3'h0, f});
      r = alu(f, a, b, m, ci);
      rd(3'h0, r);
      drain("alu");
      chk("zero", {7'h00, COND_O[0]}, {7'h00, r == 8'h00});
    end
    for (int i = 0; i < 4; i++) wr(3'h4, (v[i] = 8'($urandom)));
    wr(3'h4, 8'hA5);
    tick(2);
    chk("full", {7'h00, COND_O[2]}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      op(16'h1000);
      rd(3'h2, v[(i == 4) ? 3 : i]);
      drain("queue in");
    end
    chk("empty", {7'h00, COND_O[1]}, 8'h01);
    stall <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(3'h1, (v[i] = 8'($urandom)));
      op(16'h8000);
    end
    wr(3'h5, 8'h3C);
    for (int i = 0; i < 5; i++) rd(3'h5, (i < 4) ? v[i] : 8'h00);
    drain("queue out");
    stall <= 1'b0;
    {PLD_T_CFG_I, PLD_C_CFG_I} <= {192'h1, 192'h1 << 96};
    {PLD_OR_CFG_I, PLD_REG_CFG_I} <= {64'h100000001, 8'h10};
    {CHAIN_EQ_I, CHAIN_Z_I, PLD_IN_I} <= 26'h0;
    tick(2);
    p12 = 1'b0;
    for (int i = 0; i < 8; i++) begin
      PLD_IN_I <= 24'($urandom);
      tick(1);
      chk("comb", {7'h00, PLD_OUT_O[0]}, {7'h00, PLD_IN_I[0]});
      chk("reg", {7'h00, PLD_OUT_O[4]}, {7'h00, !p12});
      p12 = PLD_IN_I[12];
    end
    close_out();
  end
endmodule
bind plc_cell plc_cell_props u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .BUS_RD_I(BUS_RD_I), .BUS_RD_READY_O(BUS_RD_READY_O),
  .BUS_RVALID_O(BUS_RVALID_O), .BUS_RREADY_I(BUS_RREADY_I),
  .BUS_RDATA_O(BUS_RDATA_O), .PLD_OR_CFG_I(PLD_OR_CFG_I),
  .PLD_REG_CFG_I(PLD_REG_CFG_I), .PLD_OUT_O(PLD_OUT_O),
  .CHAIN_EQ_I(CHAIN_EQ_I), .CHAIN_EQ_O(CHAIN_EQ_O),
  .CHAIN_Z_I(CHAIN_Z_I), .CHAIN_Z_O(CHAIN_Z_O));
`default_nettype wire
